/* File: bcs_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_channel
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire bcs_pkg::bcs_apb_in_type apbIn,
    output bcs_pkg::bcs_apb_out_type apbOut,
    output bcs_pkg::bcs_mem_req_type memReq,
    input wire bcs_pkg::bcs_mem_rsp_type memRsp,
    output bcs_pkg::bcs_per_req_type perReq,
    input wire bcs_pkg::bcs_per_rsp_type perRsp,
    output logic eopIrq
);
    import bcs_pkg::*;

    bcs_state_type s;
    bcs_state_type next_s;
    logic busy;
    logic setupAcc;
    logic fire;
    logic cmdWr;
    logic startOut;
    logic startIn;
    logic termEv;
    logic knownAddr;
    logic busyErr;
    logic [WORD_W-1:0] statusWord;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign busy = (s.phase != PH_IDLE);
    assign setupAcc = apbIn.psel & apbIn.penable & ~s.apb.pready;
    // One wait state; the write lands on the edge that sees pready
    assign fire = apbIn.psel & apbIn.penable & s.apb.pready & apbIn.pwrite
        & ~s.apb.pslverr;
    assign cmdWr = fire & (apbIn.paddr == OFS_CMD);
    assign startOut = cmdWr & apbIn.pwdata[CMD_OUT];
    assign startIn = cmdWr & apbIn.pwdata[CMD_IN] & ~apbIn.pwdata[CMD_OUT];
    assign termEv = cmdWr & apbIn.pwdata[CMD_TERM];
    assign knownAddr = (apbIn.paddr == OFS_CMD) | (apbIn.paddr == OFS_FWA)
        | (apbIn.paddr == OFS_LWA) | (apbIn.paddr == OFS_CWA)
        | (apbIn.paddr == OFS_STATUS) | (apbIn.paddr == OFS_EQUIP)
        | (apbIn.paddr == OFS_DIRECT);
    // A second start while busy would corrupt the running block
    assign busyErr = busy & apbIn.pwrite & ((apbIn.paddr == OFS_DIRECT)
        | ((apbIn.paddr == OFS_CMD)
        & (apbIn.pwdata[CMD_OUT] | apbIn.pwdata[CMD_IN])));

    always_comb
    begin
        statusWord = '0;
        statusWord[ST_READY] = ~busy;
        statusWord[ST_BUSY] = busy;
        statusWord[ST_INT] = s.intPend;
        statusWord[ST_EOP_EN] = s.eopEn;
        statusWord[ST_EOP] = s.eop;
        statusWord[ST_REJECT] = s.reject;
        statusWord[ST_REPLY] = s.reply;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic doneNow;
        doneNow = 1'b0;
        next_s = s;
        next_s.per.fnStrobe = 1'b0;
        next_s.per.fnClear = 1'b0;
        next_s.apb.pready = setupAcc;
        next_s.apb.pslverr = setupAcc & (~knownAddr | busyErr);
        if (setupAcc)
        begin
            next_s.apb.prdata = 32'h0000_0000;
            if (!apbIn.pwrite)
            begin
                case (apbIn.paddr)
                    OFS_FWA: next_s.apb.prdata[WORD_W-1:0] = s.fwa;
                    OFS_LWA: next_s.apb.prdata[WORD_W-1:0] = s.last_word_address;
                    OFS_CWA: next_s.apb.prdata[WORD_W-1:0] = s.current_word_address;
                    OFS_STATUS:
                        next_s.apb.prdata[WORD_W-1:0] = statusWord;
                    OFS_EQUIP: next_s.apb.prdata[EQUIP_W-1:0] = s.per.equip;
                    default: next_s.apb.prdata = 32'h0000_0000;
                endcase
            end
        end
        if (fire)
        begin
            case (apbIn.paddr)
                OFS_FWA: next_s.fwa = apbIn.pwdata[WORD_W-1:0];
                OFS_LWA: next_s.last_word_address = apbIn.pwdata[WORD_W-1:0];
                OFS_EQUIP: next_s.per.equip = apbIn.pwdata[EQUIP_W-1:0];
                OFS_DIRECT:
                begin
                    next_s.per.fnStrobe = 1'b1;
                    next_s.per.fnData = apbIn.pwdata[WORD_W-1:0];
                end
                default: next_s.per.fnStrobe = 1'b0;
            endcase
        end
        // Clearing happens first so a completion in the same cycle wins
        if (cmdWr & apbIn.pwdata[CMD_EOP_CLR])
        begin
            next_s.eopEn = 1'b0;
            next_s.intPend = 1'b0;
        end
        if (cmdWr & apbIn.pwdata[CMD_EOP_SEL])
        begin
            next_s.eopEn = 1'b1;
        end
        // Clear controller is not refused while busy unless the same write also sets OUT or IN
        if (cmdWr & apbIn.pwdata[CMD_CLEAR_CTL])
        begin
            next_s.per.fnClear = 1'b1;
        end
        if (s.per.req & perRsp.reject)
        begin
            next_s.reject = 1'b1;
        end

        // --------------------------------------------------------
        // Word transfer sequence
        // --------------------------------------------------------
        case (s.phase)
            PH_IDLE:
            begin
                next_s.per.req = 1'b0;
            end
            PH_MEM_RD:
            begin
                next_s.mem.req = 1'b1;
                next_s.mem.we = 1'b0;
                next_s.mem.addr = s.current_word_address;
                if (s.mem.req & memRsp.ack)
                begin
                    next_s.mem.req = 1'b0;
                    next_s.per.data = memRsp.rdata;
                    next_s.phase = PH_PER_OUT;
                end
            end
            PH_PER_OUT, PH_PER_IN:
            begin
                // No answer means no advance: an absent device stalls here
                if (s.per.req & perRsp.reply)
                begin
                    next_s.per.req = 1'b0;
                    if (s.phase == PH_PER_IN)
                    begin
                        next_s.mem.req = 1'b1;
                        next_s.mem.we = 1'b1;
                        next_s.mem.addr = s.current_word_address;
                        next_s.mem.wdata = perRsp.data;
                        next_s.phase = PH_MEM_WR;
                    end
                    else
                    begin
                        next_s.current_word_address = s.current_word_address + 16'h0001;
                        doneNow = (s.current_word_address == s.last_word_address);
                        next_s.phase = PH_MEM_RD;
                    end
                end
                else if (s.per.req & perRsp.reject)
                begin
                    // Drop for one cycle, then offer the word again
                    next_s.per.req = 1'b0;
                end
                else
                begin
                    next_s.per.req = 1'b1;
                end
            end
            PH_MEM_WR:
            begin
                if (s.mem.req & memRsp.ack)
                begin
                    next_s.mem.req = 1'b0;
                    next_s.current_word_address = s.current_word_address + 16'h0001;
                    doneNow = (s.current_word_address == s.last_word_address);
                    next_s.phase = PH_PER_IN;
                end
            end
            default:
            begin
                next_s.phase = PH_IDLE;
            end
        endcase

        if (startOut | startIn)
        begin
            next_s.current_word_address = s.fwa + 16'h0001;
            next_s.eop = 1'b0;
            next_s.intPend = 1'b0;
            next_s.reply = 1'b1;
            next_s.reject = 1'b0;
            next_s.per.dirIn = startIn;
            next_s.phase = startIn ? PH_PER_IN : PH_MEM_RD;
            doneNow = (s.fwa == s.last_word_address);
        end
        if (termEv & busy)
        begin
            doneNow = 1'b1;
        end
        if (doneNow)
        begin
            next_s.phase = PH_IDLE;
            next_s.mem.req = 1'b0;
            next_s.per.req = 1'b0;
            next_s.eop = 1'b1;
            // Flag and line rise on the same edge as end of operation
            if (s.eopEn)
            begin
                next_s.intPend = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= RST_STATE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign apbOut = s.apb;
    assign memReq = s.mem;
    assign perReq = s.per;
    assign eopIrq = s.intPend;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence seqStart;
        (startOut | startIn) && (s.fwa != s.last_word_address);
    endsequence

    sequence seqReadReg(logic [ADDR_W-1:0] ofs);
        setupAcc && !apbIn.pwrite && (apbIn.paddr == ofs);
    endsequence

    a_busy_on_start: assert property (
        seqStart |=> busy && statusWord[ST_BUSY])
        else $error("busy not set after start");
    a_reply_on_start: assert property (
        (startOut | startIn) |=> s.reply && !s.reject)
        else $error("reply not set after start");
    a_reject_seen: assert property (
        (s.per.req && perRsp.reject && !(startOut | startIn)) |=> s.reject)
        else $error("peripheral reject not reported");
    a_eop_not_busy: assert property (
        !(s.eop && busy))
        else $error("end of operation shown while busy");
    a_eop_at_end: assert property (
        $fell(busy) |-> s.eop && statusWord[ST_READY])
        else $error("end of operation missing after busy fell");
    a_irq_on_end: assert property (
        ($fell(busy) && $past(s.eopEn)) |-> eopIrq)
        else $error("interrupt missing at completion");
    a_int_status: assert property (
        seqReadReg(OFS_STATUS) |=> apbOut.prdata[ST_INT] == $past(eopIrq))
        else $error("interrupt bit not shown in status");
    a_eop_with_irq: assert property (
        $rose(eopIrq) |-> s.eop && !busy)
        else $error("interrupt rose before end of operation");
    a_cwa_start: assert property (
        (startOut | startIn) |=> s.current_word_address == $past(s.fwa) + 16'h0001)
        else $error("current address wrong after start");
    a_cwa_step: assert property (
        (busy && !(startOut | startIn)) |=>
        (s.current_word_address == $past(s.current_word_address)) || (s.current_word_address == $past(s.current_word_address) + 16'h0001))
        else $error("current address moved back or jumped");
    a_direct_busy: assert property (
        (setupAcc && busy && apbIn.pwrite && apbIn.paddr == OFS_DIRECT)
        |=> apbOut.pslverr ##1 !perReq.fnStrobe)
        else $error("direct function accepted while busy");
    a_end_exact: assert property (
        ($fell(busy) && !$past(termEv)) |-> s.current_word_address == s.last_word_address + 16'h0001)
        else $error("transfer ended at wrong address");
    // The last word lifts the address past the end on the edge busy drops
    a_busy_hold: assert property (
        (busy && !termEv) |=> busy || (s.current_word_address == s.last_word_address + 16'h0001))
        else $error("busy dropped before last address");
    a_stall_absent: assert property (
        (s.phase == PH_PER_OUT && s.per.req && !perRsp.reply && !termEv)
        |=> busy && $stable(s.current_word_address))
        else $error("channel advanced without device answer");
    a_term_clean: assert property (
        (setupAcc && apbIn.pwrite && apbIn.paddr == OFS_CMD
        && apbIn.pwdata[CMD_TERM] && !apbIn.pwdata[CMD_OUT]
        && !apbIn.pwdata[CMD_IN]) |=> apbOut.pready && !apbOut.pslverr)
        else $error("terminate rejected");
    a_read_clean: assert property (
        (seqReadReg(OFS_CWA) or seqReadReg(OFS_STATUS))
        |=> apbOut.pready && !apbOut.pslverr)
        else $error("register read rejected");
    a_clear_pass: assert property (
        (cmdWr && apbIn.pwdata[CMD_CLEAR_CTL]) |=> perReq.fnClear)
        else $error("clear controller not passed on");
    a_enable_ops: assert property (
        (cmdWr && apbIn.pwdata[CMD_EOP_CLR] && !apbIn.pwdata[CMD_EOP_SEL])
        |=> !s.eopEn ##1 !statusWord[ST_EOP_EN])
        else $error("interrupt enable not cleared");
    // Select alone must arm the completion interrupt for the next block
    a_enable_sel: assert property (
        (cmdWr && apbIn.pwdata[CMD_EOP_SEL]) |=> s.eopEn)
        else $error("interrupt enable not selected");
endmodule : bcs_channel
`default_nettype wire

/* File: bcs_pkg.sv */
`default_nettype none
package bcs_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam int EQUIP_W = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FWA = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LWA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CWA = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EQUIP = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DIRECT = 8'h18;

    // ------------------------------------------------------------
    // Function word bits
    // ------------------------------------------------------------
    localparam int CMD_OUT = 0;
    localparam int CMD_IN = 1;
    localparam int CMD_TERM = 2;
    localparam int CMD_EOP_SEL = 3;
    localparam int CMD_EOP_CLR = 4;
    localparam int CMD_CLEAR_CTL = 5;

    // ------------------------------------------------------------
    // Status word bits
    // ------------------------------------------------------------
    localparam int ST_READY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_INT = 2;
    localparam int ST_EOP_EN = 3;
    localparam int ST_EOP = 4;
    localparam int ST_REJECT = 8;
    localparam int ST_REPLY = 9;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_MEM_RD = 3'b001,
        PH_PER_OUT = 3'b010,
        PH_PER_IN = 3'b011,
        PH_MEM_WR = 3'b100
    } bcs_phase_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } bcs_apb_in_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bcs_apb_out_type;

    typedef struct packed {
        logic req;
        logic we;
        logic [WORD_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } bcs_mem_req_type;

    typedef struct packed {
        logic ack;
        logic [WORD_W-1:0] rdata;
    } bcs_mem_rsp_type;

    typedef struct packed {
        logic req;
        logic dirIn;
        logic [EQUIP_W-1:0] equip;
        logic [WORD_W-1:0] data;
        logic fnStrobe;
        logic fnClear;
        logic [WORD_W-1:0] fnData;
    } bcs_per_req_type;

    typedef struct packed {
        logic reply;
        logic reject;
        logic [WORD_W-1:0] data;
    } bcs_per_rsp_type;

    typedef struct packed {
        bcs_phase_type phase;
        logic [WORD_W-1:0] fwa;
        logic [WORD_W-1:0] last_word_address;
        logic [WORD_W-1:0] current_word_address;
        logic eopEn;
        logic eop;
        logic intPend;
        logic reject;
        logic reply;
        bcs_apb_out_type apb;
        bcs_mem_req_type mem;
        bcs_per_req_type per;
    } bcs_state_type;

    localparam bcs_state_type RST_STATE = '0;
endpackage : bcs_pkg
`default_nettype wire

/* File: bcs_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_far_model
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire bcs_pkg::bcs_mem_req_type memReq,
    output bcs_pkg::bcs_mem_rsp_type memRsp,
    input wire bcs_pkg::bcs_per_req_type perReq,
    output bcs_pkg::bcs_per_rsp_type perRsp,
    input wire logic slow,
    input wire logic rejMode,
    input wire logic [3:0] absentEquip,
    output logic [15:0] lastOut,
    output logic [15:0] lastMemWr,
    output logic [15:0] inCnt
);
    import bcs_pkg::*;
    logic [2:0] memCnt;
    logic [2:0] perCnt;
    logic [2:0] lat;
    logic rejDone;
    assign lat = slow ? 3'h4 : 3'h1;
    // ----------------------------------------
    // Memory and peripheral answers
    // ----------------------------------------
    // Idle data lines toggle, so a stale word is never taken for a fresh one
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            memRsp <= '0;
            perRsp <= '0;
            memCnt <= '0;
            perCnt <= '0;
            rejDone <= 1'b0;
            lastOut <= '0;
            lastMemWr <= '0;
            inCnt <= '0;
        end
        else
        begin
            memRsp.ack <= 1'b0;
            memRsp.rdata <= ~memRsp.rdata;
            perRsp.reply <= 1'b0;
            perRsp.reject <= 1'b0;
            perRsp.data <= ~perRsp.data;
            if (memReq.req && !memRsp.ack)
            begin
                memCnt <= memCnt + 3'h1;
                if (memCnt >= lat)
                begin
                    memCnt <= 3'h0;
                    memRsp.ack <= 1'b1;
                    memRsp.rdata <= memReq.addr ^ 16'ha5a5;
                    if (memReq.we)
                        lastMemWr <= memReq.wdata;
                end
            end
            // An absent unit never answers: the channel must hang
            if (perReq.req && !perRsp.reply && !perRsp.reject
                && perReq.equip != absentEquip)
            begin
                perCnt <= perCnt + 3'h1;
                if (perCnt >= lat)
                begin
                    perCnt <= 3'h0;
                    rejDone <= rejMode && !rejDone;
                    if (rejMode && !rejDone)
                        perRsp.reject <= 1'b1;
                    else
                    begin
                        perRsp.reply <= 1'b1;
                        lastOut <= perReq.data;
                        if (perReq.dirIn)
                        begin
                            perRsp.data <= 16'h1000 + inCnt;
                            inCnt <= inCnt + 16'h0001;
                        end
                    end
                end
            end
        end
    end
endmodule : bcs_far_model
`default_nettype wire

/* File: bcs_channel_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_channel_tb;
    import bcs_pkg::*;
    logic clock;
    logic sysRst;
    bcs_apb_in_type apbIn;
    bcs_apb_out_type apbOut;
    bcs_mem_req_type memReq;
    bcs_mem_rsp_type memRsp;
    bcs_per_req_type perReq;
    bcs_per_rsp_type perRsp;
    logic eopIrq;
    logic slow;
    logic rejMode;
    logic [15:0] lastOut;
    logic [15:0] lastMemWr;
    logic [15:0] inCnt;
    logic [15:0] lastFn = '0;
    logic [15:0] s;
    logic [15:0] c;
    logic [15:0] f;
    logic e;
    int clrCount = 0;
    int failCount;
    int nCompared;

    bcs_channel DUT (.clock(clock), .sys_rst(sysRst), .apbIn(apbIn),
        .apbOut(apbOut), .memReq(memReq), .memRsp(memRsp),
        .perReq(perReq), .perRsp(perRsp), .eopIrq(eopIrq));
    bcs_far_model farEnd (.clock(clock), .sys_rst(sysRst),
        .memReq(memReq), .memRsp(memRsp), .perReq(perReq),
        .perRsp(perRsp), .slow(slow), .rejMode(rejMode),
        .absentEquip(4'hf), .lastOut(lastOut), .lastMemWr(lastMemWr),
        .inCnt(inCnt));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (perReq.fnClear === 1'b1)
            clrCount <= clrCount + 1;
        if (perReq.fnStrobe === 1'b1)
            lastFn <= perReq.fnData;
    end

    // ----------------------------------------
    // Bus and comparison tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            failCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb_xfer(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] v, output logic x);
        int n;
        n = 0;
        @(posedge clock);
        apbIn <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
        @(posedge clock);
        apbIn.penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (apbOut.pready !== 1'b1 && n < 50);
        v = apbOut.prdata[15:0];
        x = apbOut.pslverr;
        apbIn <= '0;
        if (n >= 50)
            failCount++;
    endtask : apb_xfer

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d,
        input logic refused);
        logic [15:0] v;
        logic x;
        apb_xfer(1'b1, a, d, v, x);
        check(x, refused);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        logic x;
        apb_xfer(1'b0, a, 16'h0000, v, x);
        check(x, 1'b0);
    endtask : reg_rd

    task automatic run_block(input logic [15:0] cmd, input logic [15:0] fa,
        input logic [15:0] la, input logic [15:0] rejBit);
        logic [15:0] st;
        logic [15:0] cw;
        logic [15:0] pv;
        int n;
        reg_wr(OFS_CMD, 16'h0008, 1'b0);
        reg_wr(OFS_FWA, fa, 1'b0);
        reg_wr(OFS_LWA, la, 1'b0);
        reg_wr(OFS_CMD, cmd, 1'b0);
        reg_rd(OFS_CWA, pv);
        check(pv, fa + 16'h0001);
        reg_rd(OFS_STATUS, st);
        check(st & 16'h0212, 16'h0202);
        n = 0;
        while (st[1] === 1'b1 && n < 500)
        begin
            reg_rd(OFS_CWA, cw);
            check({31'h0, cw >= pv && cw - pv <= 16'h0002}, 32'h1);
            pv = cw;
            reg_rd(OFS_STATUS, st);
            check({31'h0, st[4] & st[1]}, 32'h0);
            check({31'h0, st[1] & (cw == la + 16'h1)}, 32'h0);
            n++;
        end
        reg_rd(OFS_CWA, cw);
        check(cw, la + 16'h0001);
        check(st & 16'h0116, rejBit | 16'h0014);
        check(eopIrq, 1'b1);
        reg_wr(OFS_CMD, 16'h0010, 1'b0);
        @(posedge clock);
        check(eopIrq, 1'b0);
    endtask : run_block

    task automatic test_done;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        apbIn = '0;
        sysRst = 1'b1;
        slow = 1'b0;
        rejMode = 1'b0;
        failCount = 0;
        nCompared = 0;
        repeat (5) @(posedge clock);
        sysRst <= 1'b0;
        reg_rd(OFS_STATUS, s);
        check(s, 16'h0001);
        reg_rd(OFS_CWA, c);
        reg_wr(OFS_CMD, 16'h0008, 1'b0);
        reg_rd(OFS_STATUS, s);
        check(s & 16'h0008, 16'h0008);
        reg_wr(OFS_CMD, 16'h0010, 1'b0);
        reg_rd(OFS_STATUS, s);
        check(s & 16'h0008, 16'h0000);
        reg_wr(OFS_CMD, 16'h0004, 1'b0);
        apb_xfer(1'b0, 8'h1c, 16'h0000, s, e);
        check(e, 1'b1);
        // Hang on an absent unit for blocks starting at 0000 and at 7ffe, in both directions
        reg_wr(OFS_EQUIP, 16'h000f, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            f = i[0] ? 16'h7ffe : 16'h0000;
            reg_wr(OFS_FWA, f, 1'b0);
            reg_wr(OFS_LWA, f + 16'h0003, 1'b0);
            reg_wr(OFS_CMD, i[1] ? 16'h0002 : 16'h0001, 1'b0);
            reg_rd(OFS_CWA, c);
            check(c, f + 16'h0001);
            reg_rd(OFS_STATUS, s);
            check(s & 16'h0212, 16'h0202);
            reg_wr(OFS_DIRECT, 16'h0055, 1'b1);
            reg_wr(OFS_CMD, 16'h0001, 1'b1);
            reg_wr(OFS_CMD, 16'h0004, 1'b0);
            reg_rd(OFS_STATUS, s);
            check(s & 16'h0012, 16'h0010);
        end
        check(lastFn, 16'h0000);
        reg_wr(OFS_EQUIP, 16'h0003, 1'b0);
        reg_wr(OFS_CMD, 16'h0020, 1'b0);
        reg_wr(OFS_DIRECT, 16'h00a6, 1'b0);
        repeat (2) @(posedge clock);
        check(clrCount, 1);
        check(lastFn, 16'h00a6);
        slow <= 1'b1;
        rejMode <= 1'b1;
        run_block(16'h0001, 16'h0100, 16'h010f, 16'h0100);
        check(lastOut, 16'h010f ^ 16'ha5a5);
        rejMode <= 1'b0;
        run_block(16'h0002, 16'h0200, 16'h0204, 16'h0000);
        check(inCnt, 16'h0004);
        check(lastMemWr, 16'h1003);
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        failCount++;
        test_done();
    end
endmodule : bcs_channel_tb
`default_nettype wire
